// ---- hdl/powerup_mode_select_params.svh ----
// Constants for the start-up mode selector.
// Assumes inclusion by bare name from files under hdl/.
`ifndef POWERUP_MODE_SELECT_PARAMS_SVH
`define POWERUP_MODE_SELECT_PARAMS_SVH

// ----------------------------------------------------------------
// Selection byte and buffer shape
// ----------------------------------------------------------------
`define CFG_REQUEST_BYTE 8'hFF
`define BYTE_WIDTH 8
`define FIFO_DEPTH 16
`define CFG_RAM_DEPTH 64

`endif

// ---- hdl/powerup_mode_select_pkg.sv ----
// Types for the start-up mode selector.
// Assumes the params header is compiled alongside.
package powerup_mode_select_pkg;

	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_CHECK = 3'h1,
		ST_WAIT = 3'h3,
		ST_CONFIG = 3'h2,
		ST_TEST = 3'h7,
		ST_RUN = 3'h5
	} mode_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_beat_t;

endpackage : powerup_mode_select_pkg

// ---- hdl/byte_fifo.sv ----
// Synchronous FIFO of flip-flop storage with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = s_q.mem[s_q.rd];

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = bump(s_q.wr);
		end
		if (pop) begin
			s_d.rd = bump(s_q.rd);
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : byte_fifo

// ---- hdl/powerup_mode_select.sv ----
// Start-up mode selector: stored config, config download or test mode.
// Assumes a byte UART outside, and a one-time store that reports
// validity with a done strobe after a check request.
//
// Operation
// - Power-on and every reset run the same start-up selection.
// - A valid stored configuration is loaded and run with no UART wait.
// - Without stored config, a first UART byte of 0xFF enters config mode.
// - Without stored config, any other first byte enters direct test mode.
// - One UART byte stream serves both test mode and config download.
// - Config mode writes downloaded bytes to RAM, repeatedly if desired.
// - RAM config is lost on reset and selection starts again.
// - Once the store is programmed, test mode is never entered.
// - With a valid stored configuration the UART is disabled.
// - Test and config modes hold power management off.
`timescale 1ns/10ps
`include "powerup_mode_select_params.svh"
module powerup_mode_select #(
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int RAM_DEPTH = `CFG_RAM_DEPTH,
	parameter int RAM_AW = $clog2(RAM_DEPTH)
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reset_n_pin,
	output logic otp_check_req,
	input wire logic otp_check_done,
	input wire logic otp_valid,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	output logic test_valid,
	input wire logic test_ready,
	output logic [7:0] test_data,
	output logic cfg_mode,
	output logic test_mode,
	output logic run_mode,
	output logic cfg_from_otp,
	output logic uart_enable,
	output logic power_mgmt_enable,
	output logic cfg_ram_we,
	output logic [RAM_AW-1:0] cfg_ram_addr,
	output logic [7:0] cfg_ram_data,
	output logic cfg_ram_wrap
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] pin_sync;
		powerup_mode_select_pkg::mode_state_t st;
		logic req;
		logic from_otp;
		logic we;
		logic [RAM_AW-1:0] addr;
		logic [7:0] wdata;
		logic seen;
		logic wrap;
	} ctrl_state_t;

	ctrl_state_t s_q;
	ctrl_state_t s_d;
	powerup_mode_select_pkg::byte_beat_t head;
	logic fifo_out_ready;
	logic fifo_in_ready;
	logic in_reset;

	// ----------------------------------------------------------------
	// Reset merge
	// ----------------------------------------------------------------
	// Pin seen only through the two-flop synchroniser
	assign in_reset = srst || !s_q.pin_sync[1];

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Last RAM slot, after which a download wraps
	function automatic logic last_addr(input logic [RAM_AW-1:0] a);
		last_addr = (a == RAM_AW'(RAM_DEPTH - 1));
	endfunction : last_addr

	function automatic logic [RAM_AW-1:0] next_addr(
		input logic [RAM_AW-1:0] a
	);
		if (last_addr(a)) begin
			next_addr = '0;
		end else begin
			next_addr = a + 1'b1;
		end
	endfunction : next_addr

	// First byte picks the mode
	function automatic powerup_mode_select_pkg::mode_state_t pick_mode(
		input logic [7:0] b
	);
		if (b == `CFG_REQUEST_BYTE) begin
			pick_mode = powerup_mode_select_pkg::ST_CONFIG;
		end else begin
			pick_mode = powerup_mode_select_pkg::ST_TEST;
		end
	endfunction : pick_mode

	// States in which UART bytes are taken
	function automatic logic listening(
		input powerup_mode_select_pkg::mode_state_t st
	);
		case (st)
			powerup_mode_select_pkg::ST_WAIT: listening = 1'b1;
			powerup_mode_select_pkg::ST_CONFIG: listening = 1'b1;
			powerup_mode_select_pkg::ST_TEST: listening = 1'b1;
			default: listening = 1'b0;
		endcase
	endfunction : listening

	// ----------------------------------------------------------------
	// Receive buffer
	// ----------------------------------------------------------------
	byte_fifo #(
		.WIDTH(`BYTE_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.srst(in_reset),
		.in_valid(rx_valid && uart_enable),
		.in_ready(fifo_in_ready),
		.in_data(rx_data),
		.out_valid(head.valid),
		.out_ready(fifo_out_ready),
		.out_data(head.data)
	);

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	always_comb begin
		fifo_out_ready = 1'b0;
		case (s_q.st)
			powerup_mode_select_pkg::ST_WAIT: fifo_out_ready = 1'b1;
			powerup_mode_select_pkg::ST_CONFIG: fifo_out_ready = 1'b1;
			powerup_mode_select_pkg::ST_TEST: fifo_out_ready = test_ready;
			default: fifo_out_ready = 1'b0;
		endcase
	end

	assign cfg_mode = (s_q.st == powerup_mode_select_pkg::ST_CONFIG);
	assign test_mode = (s_q.st == powerup_mode_select_pkg::ST_TEST);
	assign run_mode = (s_q.st == powerup_mode_select_pkg::ST_RUN);
	assign cfg_from_otp = s_q.from_otp;
	// UART shut outside the byte-driven states
	assign uart_enable = listening(s_q.st) && !in_reset;
	// Host sees no room while the UART is shut
	assign rx_ready = fifo_in_ready && uart_enable;
	assign power_mgmt_enable = run_mode;
	assign test_valid = test_mode && head.valid;
	assign test_data = head.data;
	assign otp_check_req = s_q.req;
	assign cfg_ram_we = s_q.we;
	assign cfg_ram_addr = s_q.addr;
	assign cfg_ram_data = s_q.wdata;
	assign cfg_ram_wrap = s_q.wrap;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pin_sync = {s_q.pin_sync[0], reset_n_pin};
		s_d.we = 1'b0;
		s_d.req = 1'b0;
		case (s_q.st)
			powerup_mode_select_pkg::ST_RESET: begin
				s_d.req = 1'b1;
				s_d.st = powerup_mode_select_pkg::ST_CHECK;
			end
			powerup_mode_select_pkg::ST_CHECK: begin
				if (otp_check_done) begin
					if (otp_valid) begin
						s_d.from_otp = 1'b1;
						s_d.st = powerup_mode_select_pkg::ST_RUN;
					end else begin
						s_d.st = powerup_mode_select_pkg::ST_WAIT;
					end
				end
			end
			powerup_mode_select_pkg::ST_WAIT: begin
				if (head.valid) begin
					s_d.st = pick_mode(head.data);
				end
			end
			powerup_mode_select_pkg::ST_CONFIG: begin
				if (head.valid) begin
					s_d.we = 1'b1;
					s_d.wdata = head.data;
					s_d.seen = 1'b1;
					// First byte lands at slot zero
					if (s_q.seen) begin
						s_d.addr = next_addr(s_q.addr);
						if (last_addr(s_q.addr)) begin
							s_d.wrap = 1'b1;
						end
					end
				end
			end
			powerup_mode_select_pkg::ST_TEST: begin
				s_d.st = s_q.st;
			end
			powerup_mode_select_pkg::ST_RUN: begin
				s_d.st = s_q.st;
			end
			default: s_d.st = powerup_mode_select_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (in_reset) begin
			// RAM config and mode forgotten
			s_q <= '0;
			s_q.pin_sync <= s_d.pin_sync;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : powerup_mode_select

// ---- sim/uart_host.sv ----
// Host tool model on the UART byte stream.
// Assumes the selector's rx handshake on ref_clk.
`timescale 1ns/10ps
module uart_host (
	input wire logic ref_clk,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// One stream for requests and test bytes
	task automatic send(input logic [7:0] b);
		@(negedge ref_clk);
		rx_valid = 1'b1;
		rx_data = b;
		while (!rx_ready)
			@(negedge ref_clk);
		@(posedge ref_clk);
		@(negedge ref_clk);
		rx_valid = 1'b0;
		rx_data = ~b;
	endtask : send
endmodule : uart_host

// ---- sim/powerup_mode_select_chk.sv ----
// Port checker for the start-up mode selector.
// Assumes a bind onto powerup_mode_select.
`timescale 1ns/10ps
module powerup_mode_select_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reset_n_pin,
	input wire logic otp_check_req,
	input wire logic otp_check_done,
	input wire logic otp_valid,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic test_valid,
	input wire logic cfg_mode,
	input wire logic test_mode,
	input wire logic run_mode,
	input wire logic cfg_from_otp,
	input wire logic uart_enable,
	input wire logic power_mgmt_enable,
	input wire logic cfg_ram_we
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst || !reset_n_pin);
	sequence s_idle; !cfg_mode && !test_mode && !run_mode; endsequence
	sequence s_byte; rx_valid && rx_ready && uart_enable; endsequence
	property p_req; $fell(srst) |-> ##[0:2] otp_check_req; endproperty
	a_req: assert property (p_req) else $error("no check");
	property p_run; otp_check_done && otp_valid |=> run_mode && cfg_from_otp;
	endproperty
	a_run: assert property (p_run) else $error("no run");
	property p_ff; s_idle ##0 s_byte ##0 rx_data == 8'hFF
		|-> ##[1:4] cfg_mode; endproperty
	a_ff: assert property (p_ff) else $error("no cfg");
	property p_dtm; s_idle ##0 s_byte ##0 rx_data != 8'hFF
		|-> ##[1:4] test_mode; endproperty
	a_dtm: assert property (p_dtm) else $error("no test");
	property p_fwd; test_mode ##0 s_byte |-> ##[1:4] test_valid; endproperty
	a_fwd: assert property (p_fwd) else $error("no fwd");
	property p_ram; cfg_mode ##0 s_byte |-> ##[1:4] cfg_ram_we; endproperty
	a_ram: assert property (p_ram) else $error("no write");
	property p_one; $onehot0({cfg_mode, test_mode, run_mode}); endproperty
	a_one: assert property (p_one) else $error("modes mix");
	property p_uart; cfg_from_otp |-> !uart_enable; endproperty
	a_uart: assert property (p_uart) else $error("uart on");
	property p_pm; power_mgmt_enable == run_mode; endproperty
	a_pm: assert property (p_pm) else $error("pm wrong");
	property p_pin; $rose(reset_n_pin) |-> ##[2:4] otp_check_req; endproperty
	a_pin: assert property (p_pin) else $error("no restart");
	property p_wait; otp_check_done && !otp_valid |=> s_idle ##0 uart_enable;
	endproperty
	a_wait: assert property (p_wait) else $error("no wait");
	property p_nodtm; cfg_from_otp |-> !test_mode; endproperty
	a_nodtm: assert property (p_nodtm) else $error("test after store");
	property p_shut; !uart_enable |-> !rx_ready; endproperty
	a_shut: assert property (p_shut) else $error("ready while shut");
endmodule : powerup_mode_select_chk

// ---- sim/tb_powerup_mode_select.sv ----
// Testbench for the start-up mode selector.
// Assumes the checker and host model are compiled first.
`timescale 1ns/10ps
module tb_powerup_mode_select;
	logic ref_clk = 1'b0, srst = 1'b1, reset_n_pin = 1'b1;
	logic otp_check_done = 1'b0, otp_valid = 1'b0, test_ready = 1'b1;
	logic otp_check_req, rx_valid, rx_ready, test_valid, cfg_mode;
	logic test_mode, run_mode, cfg_from_otp, uart_enable, otp_ok = 1'b0;
	logic power_mgmt_enable, cfg_ram_we, cfg_ram_wrap;
	logic [7:0] rx_data, test_data, cfg_ram_data, ram_d = 8'h00, fwd = 8'h00;
	logic [5:0] cfg_ram_addr, ram_a = 6'h3F;
	int err_total = 0, num_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	powerup_mode_select DUT (
		.ref_clk(ref_clk),
		.srst(srst),
		.reset_n_pin(reset_n_pin),
		.otp_check_req(otp_check_req),
		.otp_check_done(otp_check_done),
		.otp_valid(otp_valid),
		.rx_valid(rx_valid),
		.rx_ready(rx_ready),
		.rx_data(rx_data),
		.test_valid(test_valid),
		.test_ready(test_ready),
		.test_data(test_data),
		.cfg_mode(cfg_mode),
		.test_mode(test_mode),
		.run_mode(run_mode),
		.cfg_from_otp(cfg_from_otp),
		.uart_enable(uart_enable),
		.power_mgmt_enable(power_mgmt_enable),
		.cfg_ram_we(cfg_ram_we),
		.cfg_ram_addr(cfg_ram_addr),
		.cfg_ram_data(cfg_ram_data),
		.cfg_ram_wrap(cfg_ram_wrap)
	);
	uart_host host (
		.ref_clk(ref_clk),
		.rx_ready(rx_ready),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);
	// -------------------------------
	// Store model and output capture
	// -------------------------------
	always @(negedge ref_clk) begin
		otp_check_done <= otp_check_req;
		otp_valid <= otp_ok;
	end
	always @(posedge ref_clk) begin
		if (cfg_ram_we) begin
			ram_a <= cfg_ram_addr;
			ram_d <= cfg_ram_data;
		end
		if (test_valid && test_ready)
			fwd <= test_data;
	end
	task automatic chk(input string nm, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic rst(input logic pin, input logic ok);
		@(negedge ref_clk);
		otp_ok = ok;
		if (pin) reset_n_pin = 1'b0;
		else srst = 1'b1;
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		reset_n_pin = 1'b1;
		repeat (8) @(negedge ref_clk);
	endtask : rst
	task automatic wt(input logic [2:0] m);
		for (int i = 0; i < 20 && {cfg_mode, test_mode, run_mode} !== m; i++)
			@(negedge ref_clk);
	endtask : wt
	function automatic logic [7:0] st();
		return {2'h0, cfg_mode, test_mode, run_mode, cfg_from_otp,
			uart_enable, power_mgmt_enable};
	endfunction : st
	task automatic t_stored;
		rst(1'b0, 1'b1);
		wt(3'h1);
		chk("stored", st(), 8'h0D);
		chk("uart shut", {7'h00, rx_ready}, 8'h00);
		$display("stored config test done");
	endtask : t_stored
	task automatic t_cfg;
		rst(1'b0, 1'b0);
		chk("waiting", st(), 8'h02);
		host.send(8'hFF);
		wt(3'h4);
		chk("cfg", st(), 8'h22);
		host.send(8'h5A);
		host.send(8'hA5);
		repeat (6) @(negedge ref_clk);
		chk("ram addr", {2'h0, ram_a}, 8'h01);
		chk("ram data", ram_d, 8'hA5);
		for (int i = 2; i < 64; i++)
			host.send(8'(i));
		repeat (6) @(negedge ref_clk);
		chk("ram last", {2'h0, ram_a}, 8'h3F);
		chk("no wrap", {7'h00, cfg_ram_wrap}, 8'h00);
		host.send(8'hC3);
		repeat (6) @(negedge ref_clk);
		chk("ram wrap", {2'h0, ram_a}, 8'h00);
		chk("wrap data", ram_d, 8'hC3);
		chk("wrap", {7'h00, cfg_ram_wrap}, 8'h01);
		$display("config download test done");
	endtask : t_cfg
	task automatic t_dtm;
		rst(1'b1, 1'b0);
		chk("pin reset", st(), 8'h02);
		host.send(8'hFE);
		wt(3'h2);
		chk("test", st(), 8'h12);
		host.send(8'h3C);
		repeat (6) @(negedge ref_clk);
		chk("fwd", fwd, 8'h3C);
		test_ready = 1'b0;
		host.send(8'h77);
		repeat (4) @(negedge ref_clk);
		chk("held", {7'h00, test_valid}, 8'h01);
		chk("held data", test_data, 8'h77);
		chk("fwd stalled", fwd, 8'h3C);
		test_ready = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("fwd late", fwd, 8'h77);
		$display("test mode test done");
	endtask : t_dtm
	initial begin
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		t_stored();
		t_cfg();
		t_dtm();
		stop_test();
	end
	initial begin
		#5000;
		err_total++;
		stop_test();
	end
endmodule : tb_powerup_mode_select
bind powerup_mode_select powerup_mode_select_chk chk_i (
	.ref_clk(ref_clk),
	.srst(srst),
	.reset_n_pin(reset_n_pin),
	.otp_check_req(otp_check_req),
	.otp_check_done(otp_check_done),
	.otp_valid(otp_valid),
	.rx_valid(rx_valid),
	.rx_ready(rx_ready),
	.rx_data(rx_data),
	.test_valid(test_valid),
	.cfg_mode(cfg_mode),
	.test_mode(test_mode),
	.run_mode(run_mode),
	.cfg_from_otp(cfg_from_otp),
	.uart_enable(uart_enable),
	.power_mgmt_enable(power_mgmt_enable),
	.cfg_ram_we(cfg_ram_we)
);
